// *** bci_pkg.sv ***
// Notes on behaviour
// - and accumulator with file, update null flag
// - destination bit selects accumulator or file
// - skip next when tested bit low
// - skip next when tested bit high
// - taken skip executes nop, two cycles
// - clear accumulator loads zero, sets null flag
// - call pushes program counter plus one
// - call loads literal into pc low byte
// - pc 10:9 from status 6:5, bit8 zero
// - call always takes two cycles
// - watchdog kick zeroes watchdog counter
// - kick clears prescaler only when watchdog-assigned
// - kick sets expiry and power-down flags
package bci_pkg;
   // opcode fields of a 12-bit instruction word
   localparam logic [5:0]  OP_AND_FILE  = 6'h05;      // 0001_01df_ffff
   localparam logic [3:0]  OP_SKIP_LOW  = 4'h6;       // 0110_bbbf_ffff
   localparam logic [3:0]  OP_SKIP_HIGH = 4'h7;       // 0111_bbbf_ffff
   localparam logic [3:0]  OP_CALL      = 4'h9;       // 1001_kkkk_kkkk
   localparam logic [11:0] OP_CLEAR_ACC = 12'h040;    // 0000_0100_0000
   localparam logic [11:0] OP_KICK      = 12'h004;    // 0000_0000_0100
   localparam logic [11:0] OP_NOP       = 12'h000;
   // status bit positions
   localparam int ST_NULL   = 2;
   localparam int ST_PDOWN  = 3;
   localparam int ST_EXPIRY = 4;
   localparam int ST_PAGE_LO = 5;
   // reset values
   localparam logic [7:0]  ACC_RST    = 8'h00;
   localparam logic [7:0]  STATUS_RST = 8'h18;
   localparam logic [10:0] PC_RST     = 11'h000;
   localparam logic [7:0]  WDT_RST    = 8'h00;
   localparam logic [7:0]  PRE_RST    = 8'h00;
   // decoded instruction carrier
   typedef struct packed {
      logic       and_file;
      logic       skip_low;
      logic       skip_high;
      logic       clear_acc;
      logic       call;
      logic       kick;
      logic       dest;
      logic [2:0] bit_sel;
      logic [4:0] faddr;
      logic [7:0] lit;
   } bci_dec_t;
endpackage

// *** bci_decode.sv ***
`timescale 1ns/1ps
module bci_decode
   import bci_pkg::*;
(
   // instruction in
   input  wire logic [11:0] instr,
   // decoded out
   output bci_dec_t         dec
);
   // pure field split, no state
   always_comb begin
      dec           = '0;
      dec.and_file  = (instr[11:6] == OP_AND_FILE);
      dec.skip_low  = (instr[11:8] == OP_SKIP_LOW);
      dec.skip_high = (instr[11:8] == OP_SKIP_HIGH);
      dec.call      = (instr[11:8] == OP_CALL);
      dec.clear_acc = (instr == OP_CLEAR_ACC);
      dec.kick      = (instr == OP_KICK);
      dec.dest      = instr[5];
      dec.bit_sel   = instr[7:5];
      dec.faddr     = instr[4:0];
      dec.lit       = instr[7:0];
   end
endmodule

// *** bci_core.sv ***
`timescale 1ns/1ps
module bci_core
   import bci_pkg::*;
(
   // clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RESET,
   // instruction issue
   input  wire logic        INSTR_VALID,
   input  wire logic [11:0] INSTR,
   input  wire logic        PRESCALER_TO_WDT,
   // file read port (combinational, any address 0..31)
   output logic [4:0]       FILE_ADDR,
   input  wire logic [7:0]  FILE_RDATA,
   // file write-back
   output logic             FILE_WE,
   output logic [4:0]       FILE_WADDR,
   output logic [7:0]       FILE_WDATA,
   // architectural state
   output logic [7:0]       ACC,
   output logic [7:0]       STATUS,
   output logic [10:0]      PC,
   output logic             STACK_PUSH,
   output logic [10:0]      STACK_DATA,
   output logic [7:0]       WDT_COUNT,
   output logic [7:0]       PRESCALER,
   output logic             BUSY
);
   ////////////////////////////////////////////////////////////////////////
   bci_dec_t   dec;                  // decoded fields
   logic       stall_q;              // second cycle of skip or call
   logic [7:0] and_res;              // and result
   logic       bit_val;              // tested bit
   logic       exec;                 // instruction executes this cycle
   logic       take_skip;            // skip taken

   bci_decode u_dec (
      .instr (INSTR),
      .dec   (dec)
   );

   // file address straight from the instruction field
   assign FILE_ADDR = dec.faddr;
   assign and_res   = ACC & FILE_RDATA;
   assign bit_val   = FILE_RDATA[dec.bit_sel];
   // the cycle after a taken skip or a call is a forced nop, so issue is ignored then
   assign exec      = INSTR_VALID && !stall_q;
   assign take_skip = exec && ((dec.skip_low && !bit_val)
                            || (dec.skip_high && bit_val));

   ////////////////////////////////////////////////////////////////////////
   // flush cycle: taken skip or any call occupies two cycles
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         stall_q <= 1'b0;
      end else begin
         stall_q <= take_skip || (exec && dec.call);
      end
   end
   assign BUSY = stall_q;

   // accumulator
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         ACC <= ACC_RST;
      end else if (exec && dec.and_file && !dec.dest) begin
         ACC <= and_res;
      end else if (exec && dec.clear_acc) begin
         ACC <= 8'h00;
      end
   end

   // file write-back pulse for and with dest=1
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         FILE_WE    <= 1'b0;
         FILE_WADDR <= 5'h00;
         FILE_WDATA <= 8'h00;
      end else begin
         FILE_WE    <= exec && dec.and_file && dec.dest;
         FILE_WADDR <= dec.faddr;
         FILE_WDATA <= and_res;
      end
   end

   // status: only the named flags move, the rest hold
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         STATUS <= STATUS_RST;
      end else if (exec && dec.and_file) begin
         STATUS[ST_NULL] <= (and_res == 8'h00);
      end else if (exec && dec.clear_acc) begin
         STATUS[ST_NULL] <= 1'b1;
      end else if (exec && dec.kick) begin
         STATUS[ST_EXPIRY] <= 1'b1;
         STATUS[ST_PDOWN]  <= 1'b1;
      end
   end

   // program counter and stack push
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         PC         <= PC_RST;
         STACK_PUSH <= 1'b0;
         STACK_DATA <= 11'h000;
      end else begin
         STACK_PUSH <= 1'b0;
         if (exec && dec.call) begin
            STACK_PUSH <= 1'b1;
            STACK_DATA <= PC + 11'h001;
            PC <= {STATUS[ST_PAGE_LO+1:ST_PAGE_LO], 1'b0, dec.lit};
         end else if (exec || stall_q) begin
            PC <= PC + 11'h001;
         end
      end
   end

   // shared prescaler: free count; a kick touches it only when it is
   // assigned to the watchdog, so the general timer never loses a count
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         PRESCALER <= PRE_RST;
      end else if (exec && dec.kick && PRESCALER_TO_WDT) begin
         PRESCALER <= 8'h00;
      end else begin
         PRESCALER <= PRESCALER + 8'h01;
      end
   end

   // watchdog counter: steps on prescaler wrap, zeroed by a kick
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         WDT_COUNT <= WDT_RST;
      end else if (exec && dec.kick) begin
         WDT_COUNT <= 8'h00;
      end else if (PRESCALER == 8'hFF) begin
         WDT_COUNT <= WDT_COUNT + 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_skip_two;
      @(posedge SYS_CLK) disable iff (RESET) take_skip |=> stall_q;
   endproperty
   a_skip_two: assert property (p_skip_two) else $error("skip not two cycles");

   property p_call_pc;
      @(posedge SYS_CLK) disable iff (RESET) (exec && dec.call)
         |=> PC == {$past(STATUS[6:5]), 1'b0, $past(INSTR[7:0])};
   endproperty
   a_call_pc: assert property (p_call_pc) else $error("call target wrong");

   property p_call_push;
      @(posedge SYS_CLK) disable iff (RESET) (exec && dec.call)
         |=> STACK_PUSH && STACK_DATA == $past(PC) + 11'h001;
   endproperty
   a_call_push: assert property (p_call_push) else $error("push wrong");

   property p_call_two;
      @(posedge SYS_CLK) disable iff (RESET) (exec && dec.call) |=> BUSY;
   endproperty
   a_call_two: assert property (p_call_two) else $error("call one cycle");

   property p_clear_acc;
      @(posedge SYS_CLK) disable iff (RESET) (exec && dec.clear_acc)
         |=> ACC == 8'h00 && STATUS[2] && STATUS[7:3] == $past(STATUS[7:3]);
   endproperty
   a_clear_acc: assert property (p_clear_acc) else $error("clear wrong");

   property p_and_acc;
      @(posedge SYS_CLK) disable iff (RESET) (exec && dec.and_file && !dec.dest)
         |=> ACC == ($past(ACC) & $past(FILE_RDATA)) && STATUS[2] == (ACC == 8'h00);
   endproperty
   a_and_acc: assert property (p_and_acc) else $error("and result wrong");

   property p_and_file;
      @(posedge SYS_CLK) disable iff (RESET) (exec && dec.and_file && dec.dest)
         |=> FILE_WE && ACC == $past(ACC);
   endproperty
   a_and_file: assert property (p_and_file) else $error("and dest wrong");

   property p_kick;
      @(posedge SYS_CLK) disable iff (RESET) (exec && dec.kick)
         |=> WDT_COUNT == 8'h00 && STATUS[4] && STATUS[3]
             && (!$past(PRESCALER_TO_WDT) || PRESCALER == 8'h00);
   endproperty
   a_kick: assert property (p_kick) else $error("kick wrong");

   property p_skip_flags;
      @(posedge SYS_CLK) disable iff (RESET) (exec && (dec.skip_low || dec.skip_high))
         |=> $stable(STATUS);
   endproperty
   a_skip_flags: assert property (p_skip_flags) else $error("flags moved");

   c_skip: cover property (@(posedge SYS_CLK) disable iff (RESET) take_skip);
   c_call: cover property (@(posedge SYS_CLK) disable iff (RESET) exec && dec.call);
   c_kick: cover property (@(posedge SYS_CLK) disable iff (RESET)
                           exec && dec.kick && PRESCALER_TO_WDT);
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb
   import bci_pkg::*;
;
   // expected outcome of one issue slot
   typedef struct packed {
      logic [7:0]  acc;
      logic [7:0]  st;
      logic [10:0] pc;
      logic        busy;
      logic        push;
      logic        we;
      logic        kick;
      logic [10:0] aux;  // return address, write address or prescaler
      logic [7:0]  wd;   // write-back data of an and to the file
   } bci_exp_t;
   ////////////////////////////////////////////////////////////////////////////////
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        instr_valid = 1'b0;
   logic        pre_to_wdt = 1'b0;
   logic [11:0] instr = OP_NOP;
   logic [7:0]  file_q [32];     // file contents, never written back
   logic [4:0]  file_addr, file_waddr;
   logic [7:0]  file_wdata, acc, status, wdt_count, prescaler;
   logic        file_we, stack_push, busy;
   logic [10:0] pc, stack_data;
   logic [7:0]  m_acc, m_st;     // reference state
   logic [10:0] m_pc;
   logic        m_busy = 1'b0;
   int          pre_m = 0;       // cycles since the last assigned kick
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          seed = 74578;
   bci_exp_t    q [$];
   bci_exp_t    e;
   // 250 MHz
   always #2 sys_clk = ~sys_clk;
   bci_core dut_u (.SYS_CLK(sys_clk), .RESET(reset), .INSTR_VALID(instr_valid),
      .INSTR(instr), .PRESCALER_TO_WDT(pre_to_wdt), .FILE_ADDR(file_addr),
      .FILE_RDATA(file_q[file_addr]), .FILE_WE(file_we), .FILE_WADDR(file_waddr),
      .FILE_WDATA(file_wdata), .ACC(acc), .STATUS(status), .PC(pc),
      .STACK_PUSH(stack_push), .STACK_DATA(stack_data), .WDT_COUNT(wdt_count),
      .PRESCALER(prescaler), .BUSY(busy));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [10:0] seen, input logic [10:0] want);
      comparisons++;
      if (seen !== want) begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   // one issue slot; a slot right after a taken skip or call is refused
   task automatic step(input logic [11:0] ins);
      bci_exp_t x;
      logic [7:0] fv;
      fv = file_q[ins[4:0]];
      instr <= ins;
      @(posedge sys_clk);
      x = '0;
      m_pc = m_pc + 11'h001;
      pre_m++;
      if (!m_busy) begin
         if (ins[11:6] == OP_AND_FILE) begin
            x.we = ins[5];
            x.aux = 11'(ins[4:0]);
            x.wd = m_acc & fv;
            m_st[ST_NULL] = ((m_acc & fv) == 8'h00);
            if (!ins[5]) m_acc = m_acc & fv;
         end
         if (ins == OP_CLEAR_ACC) begin
            m_acc = 8'h00;
            m_st[ST_NULL] = 1'b1;
         end
         // low skip has opcode bit 8 clear, high skip has it set
         if (ins[11:9] == 3'h3) x.busy = (fv[ins[7:5]] == ins[8]);
         if (ins[11:8] == OP_CALL) begin
            x.push = 1'b1;
            x.busy = 1'b1;
            x.aux = m_pc;
            m_pc = {m_st[ST_PAGE_LO+:2], 1'b0, ins[7:0]};
         end
         if (ins == OP_KICK) begin
            x.kick = 1'b1;
            m_st[ST_EXPIRY] = 1'b1;
            m_st[ST_PDOWN] = 1'b1;
            if (pre_to_wdt) pre_m = 0;
            x.aux = 11'(pre_m);
         end
      end
      x.acc = m_acc;
      x.st = m_st;
      x.pc = m_pc;
      m_busy = x.busy;
      q.push_back(x);
   endtask
   // monitor: each settled result is matched against the oldest note
   always @(negedge sys_clk) begin
      if (q.size() > 0) begin
         e = q.pop_front();
         check(11'(acc), 11'(e.acc));
         check(11'(status), 11'(e.st));
         check(pc, e.pc);
         check(11'(busy), 11'(e.busy));
         check(11'(stack_push), 11'(e.push));
         check(11'(file_we), 11'(e.we));
         if (e.push) check(stack_data, e.aux);
         if (e.we) check(11'(file_waddr), e.aux);
         if (e.we) check(11'(file_wdata), 11'(e.wd));
         if (e.kick) check(11'(wdt_count), 11'h000);
         if (e.kick) check(11'(prescaler), e.aux);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 32; i++) file_q[i] = 8'($random(seed));
      m_acc = ACC_RST;
      m_st = STATUS_RST;
      m_pc = PC_RST;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      check({acc, 3'h0}, {ACC_RST, 3'h0});
      check(11'(status), 11'(STATUS_RST));
      @(posedge sys_clk);
      reset <= 1'b0;
      instr_valid <= 1'b1;
      // random files, both destinations
      repeat (16) step({OP_AND_FILE, 1'($random(seed)), 5'($random(seed))});
      step(OP_CLEAR_ACC);
      $display("test and_file clear_acc done");
      // every bit of both skips; the call after it is refused only if skipped
      for (int b = 0; b < 16; b++) begin
         step({(b > 7) ? OP_SKIP_HIGH : OP_SKIP_LOW, 3'(b), 5'($random(seed))});
         step({OP_CALL, 8'($random(seed))});
         step(OP_NOP);
      end
      $display("test skip call done");
      // let the prescaler wrap so the watchdog count is nonzero before a kick
      repeat (200) step(OP_NOP);
      // kick with the prescaler assigned, then unassigned six slots later
      pre_to_wdt <= 1'b1;
      step(OP_KICK);
      pre_to_wdt <= 1'b0;
      repeat (5) step(OP_NOP);
      step(OP_KICK);
      $display("test kick done");
      // bounded drain of pending notes
      for (int i = 0; i < 4 && q.size() > 0; i++) @(posedge sys_clk);
      if (q.size() > 0) n_mismatch++;
      results();
   end
endmodule
